/* File: core/pad_mux_pkg.sv */
package pad_mux_pkg;

  // ****************************************************************
  // Sizes and select codes
  // ****************************************************************

  // Number of multiplexed pads.
  localparam int unsigned PAD_COUNT = 9;
  // Width of one function-select field.
  localparam int unsigned FUNC_W = 3;
  // Width of one pull-select field.
  localparam int unsigned PULL_W = 2;

  // Function codes, column order of the pad function table.
  localparam logic [2:0] FUNC_GPIO_IN  = 3'h0;
  localparam logic [2:0] FUNC_ALT_1    = 3'h1;
  localparam logic [2:0] FUNC_ALT_2    = 3'h2;
  localparam logic [2:0] FUNC_ALT_3    = 3'h3;
  localparam logic [2:0] FUNC_ALT_4    = 3'h4;
  localparam logic [2:0] FUNC_ANALOG   = 3'h5;
  localparam logic [2:0] FUNC_GPIO_OUT = 3'h6;
  localparam logic [2:0] FUNC_GPIO_DIS = 3'h7;

  // Pull codes.
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  // Reset values of each field.
  localparam logic [2:0] FUNC_RESET = FUNC_GPIO_DIS;
  localparam logic [1:0] PULL_RESET = PULL_NONE;

  // Reset levels of the pad pull-ups (pads 3 to 8) and of the peripheral input lines.
  localparam logic [8:0] PAD_PU_RESET    = 9'h1F8;
  localparam logic [5:0] PERIPH_IN_RESET = 6'h2E;

  // Pad indices with fixed roles.
  localparam int unsigned PAD_STRAP = 5;

  // Cycles after reset release at which the strap is sampled.
  localparam logic [3:0] STRAP_DELAY = 4'h8;

  // Start-up sequencer states.
  typedef enum logic [2:0] {
    ST_WAIT   = 3'b001,
    ST_DLOAD  = 3'b010,
    ST_NORMAL = 3'b100
  } boot_state_t;

endpackage

/* File: core/pad_cfg_store.sv */
// ****************************************************************
// Per-pad function and pull select storage
// ****************************************************************
module pad_cfg_store
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_pad,
  input  wire logic [2:0]  wr_func,
  input  wire logic [1:0]  wr_pull,
  output logic      [26:0] func_sel,
  output logic      [17:0] pull_sel
);

  typedef struct packed {
    logic [26:0] func;
    logic [17:0] pull;
  } store_t;

  store_t state_reg;
  store_t state_next;

  // Writes one pad's fields, addressed by index; other indices are ignored.
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < pad_mux_pkg::PAD_COUNT; i++)
    begin
      if (wr_en && wr_pad == 4'(i))
      begin
        state_next.func[i*3 +: 3] = wr_func;
        state_next.pull[i*2 +: 2] = wr_pull;
      end
    end
  end

  // Registers the state; both fields reset to disabled input, no pull.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg.func <= {pad_mux_pkg::PAD_COUNT{pad_mux_pkg::FUNC_RESET}};
      state_reg.pull <= {pad_mux_pkg::PAD_COUNT{pad_mux_pkg::PULL_RESET}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign func_sel = state_reg.func;
  assign pull_sel = state_reg.pull;

endmodule // pad_cfg_store

/* File: core/boot_strap_seq.sv */
// ****************************************************************
// Start-up sequencer and boot strap capture
// ****************************************************************
module boot_strap_seq
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic strap_in,
  output logic      boot_done,
  output logic      download_mode
);

  typedef struct packed {
    pad_mux_pkg::boot_state_t st;
    logic [3:0]               cnt;
  } seq_t;

  seq_t state_reg;
  seq_t state_next;

  // Waits a short settle time with pull-ups on, then samples the strap once.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg.st)
      pad_mux_pkg::ST_WAIT:
      begin
        if (state_reg.cnt == pad_mux_pkg::STRAP_DELAY)
        begin
          state_next.st = strap_in ? pad_mux_pkg::ST_DLOAD : pad_mux_pkg::ST_NORMAL;
        end
        else
        begin
          state_next.cnt = state_reg.cnt + 4'h1;
        end
      end
      default:
      begin
        state_next = state_reg;
      end
    endcase
  end

  // Registers the sequencer.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg.st  <= pad_mux_pkg::ST_WAIT;
      state_reg.cnt <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign boot_done     = (state_reg.st != pad_mux_pkg::ST_WAIT);
  assign download_mode = (state_reg.st == pad_mux_pkg::ST_DLOAD);

endmodule // boot_strap_seq

/* File: core/pad_function_mux.sv */
// Notes on behaviour
// - Reset holds pads 5-8 input-off, pull-up on.
// - Pad 5 high after reset selects download.
// - Pad 5 low starts normally; four functions.
// - Firmware programs pull and function per pad.
// - Pad 6: GPIO, CTS, receive, SPI clock.
// - Pad 7: GPIO, memory clock, SPI out.
// - Pad 8: GPIO, memory data, SPI in.
// - Pads 0-2: wake-up, analog, pulse output.
// - Pads 3-4: primary, SPI, secondary UART.
// - Pads 5-6: flow, secondary, relocated primary.
// - SPI data routed to one pad only.
// - Firmware and host both set assignments.
// - Reset holds pad 3 input-off, pull-up on.
// - Download mode drops primary UART on pads 3-4, pulls them up.
module pad_function_mux
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Firmware write port.
  input  wire logic        fw_wr_en,
  input  wire logic [3:0]  fw_wr_pad,
  input  wire logic [2:0]  fw_wr_func,
  input  wire logic [1:0]  fw_wr_pull,
  // Host command write port.
  input  wire logic        host_wr_en,
  input  wire logic [3:0]  host_wr_pad,
  input  wire logic [2:0]  host_wr_func,
  input  wire logic [1:0]  host_wr_pull,
  // Status.
  output logic             boot_done,
  output logic             download_mode,
  // Pads.
  input  wire logic [8:0]  pad_in,
  output logic      [8:0]  pad_out,
  output logic      [8:0]  pad_oe,
  output logic      [8:0]  pad_ie,
  output logic      [8:0]  pad_pu,
  output logic      [8:0]  pad_pd,
  output logic      [8:0]  pad_analog,
  // GPIO core side.
  input  wire logic [8:0]  gpio_out,
  output logic      [8:0]  gpio_in,
  // Peripheral side.
  output logic             wake_up_in,
  input  wire logic        pulse_output_0,
  input  wire logic        primary_uart_transmit,
  output logic             primary_uart_receive,
  input  wire logic        primary_uart_request_to_send,
  output logic             primary_uart_clear_to_send,
  input  wire logic        secondary_uart_transmit,
  output logic             secondary_uart_receive,
  input  wire logic        spi_chip_select_out,
  input  wire logic        spi_clock_out,
  input  wire logic        spi_data_out,
  output logic             spi_data_in,
  input  wire logic        mem_i2c_clock_out,
  input  wire logic        mem_i2c_data_out,
  input  wire logic        mem_i2c_data_oe,
  output logic             mem_i2c_data_in
);

  // ****************************************************************
  // Configuration write arbitration
  // ****************************************************************

  logic        wr_en;
  logic [3:0]  wr_pad;
  logic [2:0]  wr_func;
  logic [1:0]  wr_pull;
  logic [26:0] func_sel;
  logic [17:0] pull_sel;

  // Both sources may write; firmware wins a same-cycle collision.
  always_comb
  begin
    wr_en   = boot_done && (fw_wr_en || host_wr_en);
    wr_pad  = fw_wr_en ? fw_wr_pad : host_wr_pad;
    wr_func = fw_wr_en ? fw_wr_func : host_wr_func;
    wr_pull = fw_wr_en ? fw_wr_pull : host_wr_pull;
  end

  pad_cfg_store u_store
  (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .wr_en    (wr_en),
    .wr_pad   (wr_pad),
    .wr_func  (wr_func),
    .wr_pull  (wr_pull),
    .func_sel (func_sel),
    .pull_sel (pull_sel)
  );

  boot_strap_seq u_boot
  (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .strap_in      (pad_in[pad_mux_pkg::PAD_STRAP]),
    .boot_done     (boot_done),
    .download_mode (download_mode)
  );

  // ****************************************************************
  // Per-pad decode helper
  // ****************************************************************

  // Returns the function code of one pad.
  function automatic logic [2:0] fsel(input logic [26:0] f, input int unsigned p);
    fsel = f[p*3 +: 3];
  endfunction

  // ****************************************************************
  // Output data registers
  // ****************************************************************

  typedef struct packed {
    logic [8:0] out;
    logic [8:0] oe;
    logic [8:0] ie;
    logic [8:0] pu;
    logic [8:0] pd;
    logic [8:0] an;
    logic [8:0] gin;
    logic [5:0] per;
  } pads_t;

  pads_t state_reg;
  pads_t state_next;
  logic  dl_any;

  // Builds the pad controls from the selects; all pads default to GPIO.
  always_comb
  begin
    state_next     = '0;
    dl_any         = download_mode;
    state_next.gin = pad_in;
    for (int p = 0; p < pad_mux_pkg::PAD_COUNT; p++)
    begin
      // Default plain input/output; unassigned codes fall here too.
      state_next.ie[p]  = fsel(func_sel, p) != pad_mux_pkg::FUNC_GPIO_DIS;
      state_next.oe[p]  = fsel(func_sel, p) == pad_mux_pkg::FUNC_GPIO_OUT;
      state_next.out[p] = gpio_out[p];
      state_next.pu[p]  = pull_sel[p*2 +: 2] == pad_mux_pkg::PULL_UP;
      state_next.pd[p]  = pull_sel[p*2 +: 2] == pad_mux_pkg::PULL_DOWN;
    end
    // Pad 0 wake-up; pad 1 analog; pad 2 analog or pulse output.
    state_next.per[0] = (fsel(func_sel, 0) == pad_mux_pkg::FUNC_ALT_1) & pad_in[0];
    state_next.an[1]  = fsel(func_sel, 1) == pad_mux_pkg::FUNC_ANALOG;
    state_next.an[2]  = fsel(func_sel, 2) == pad_mux_pkg::FUNC_ANALOG;
    if (fsel(func_sel, 2) == pad_mux_pkg::FUNC_ALT_1)
    begin
      state_next.oe[2]  = 1'b1;
      state_next.out[2] = pulse_output_0;
    end
    for (int p = 1; p < 3; p++)
    begin
      if (state_next.an[p])
      begin
        state_next.ie[p] = 1'b0;
      end
    end
    // Pads 3 and 4: primary UART, SPI data, secondary UART.
    case (fsel(func_sel, 3))
      pad_mux_pkg::FUNC_ALT_1:
      begin
        state_next.oe[3]  = 1'b1;
        state_next.out[3] = primary_uart_transmit;
      end
      pad_mux_pkg::FUNC_ALT_3:
      begin
        state_next.oe[3]  = 1'b1;
        state_next.out[3] = spi_data_out;
      end
      pad_mux_pkg::FUNC_ALT_4:
      begin
        state_next.oe[3]  = 1'b1;
        state_next.out[3] = secondary_uart_transmit;
      end
      default: ;
    endcase
    case (fsel(func_sel, 4))
      pad_mux_pkg::FUNC_ALT_1: state_next.per[1] = pad_in[4];
      pad_mux_pkg::FUNC_ALT_4: state_next.per[3] = pad_in[4];
      default: ;
    endcase
    // Pad 5 outputs, pad 6 inputs or SPI clock.
    case (fsel(func_sel, 5))
      pad_mux_pkg::FUNC_ALT_1:
      begin
        state_next.oe[5]  = 1'b1;
        state_next.out[5] = primary_uart_request_to_send;
      end
      pad_mux_pkg::FUNC_ALT_2:
      begin
        state_next.oe[5]  = 1'b1;
        state_next.out[5] = secondary_uart_transmit;
      end
      pad_mux_pkg::FUNC_ALT_3:
      begin
        state_next.oe[5]  = 1'b1;
        state_next.out[5] = spi_chip_select_out;
      end
      pad_mux_pkg::FUNC_ALT_4:
      begin
        state_next.oe[5]  = 1'b1;
        state_next.out[5] = primary_uart_transmit;
      end
      default: ;
    endcase
    state_next.per[2] = 1'b1;
    case (fsel(func_sel, 6))
      pad_mux_pkg::FUNC_ALT_1: state_next.per[2] = pad_in[6];
      pad_mux_pkg::FUNC_ALT_2: state_next.per[3] = pad_in[6];
      pad_mux_pkg::FUNC_ALT_3:
      begin
        state_next.oe[6]  = 1'b1;
        state_next.out[6] = spi_clock_out;
      end
      pad_mux_pkg::FUNC_ALT_4: state_next.per[1] = pad_in[6];
      default: ;
    endcase
    // Idle-high receive lines when nothing is routed to them.
    if (fsel(func_sel, 4) != pad_mux_pkg::FUNC_ALT_1 && fsel(func_sel, 6) != pad_mux_pkg::FUNC_ALT_4)
    begin
      state_next.per[1] = 1'b1;
    end
    if (fsel(func_sel, 4) != pad_mux_pkg::FUNC_ALT_4 && fsel(func_sel, 6) != pad_mux_pkg::FUNC_ALT_2)
    begin
      state_next.per[3] = 1'b1;
    end
    // Pad 7 memory clock or SPI out; pad 3 has priority for SPI out.
    if (fsel(func_sel, 7) == pad_mux_pkg::FUNC_ALT_2)
    begin
      state_next.oe[7]  = 1'b1;
      state_next.out[7] = mem_i2c_clock_out;
    end
    else if (fsel(func_sel, 7) == pad_mux_pkg::FUNC_ALT_3 && fsel(func_sel, 3) != pad_mux_pkg::FUNC_ALT_3)
    begin
      state_next.oe[7]  = 1'b1;
      state_next.out[7] = spi_data_out;
    end
    // Pad 8 memory data or SPI in; pad 4 has priority for SPI in.
    state_next.per[5] = 1'b1;
    if (fsel(func_sel, 8) == pad_mux_pkg::FUNC_ALT_2)
    begin
      state_next.oe[8]  = mem_i2c_data_oe;
      state_next.out[8] = mem_i2c_data_out;
      state_next.per[5] = pad_in[8];
    end
    if (fsel(func_sel, 4) == pad_mux_pkg::FUNC_ALT_3)
    begin
      state_next.per[4] = pad_in[4];
    end
    else if (fsel(func_sel, 8) == pad_mux_pkg::FUNC_ALT_3)
    begin
      state_next.per[4] = pad_in[8];
    end
    // Download mode drops primary UART on pads 3-4 and pulls them up.
    if (dl_any)
    begin
      for (int p = 3; p < 5; p++)
      begin
        if (fsel(func_sel, p) == pad_mux_pkg::FUNC_ALT_1)
        begin
          state_next.oe[p] = 1'b0;
        end
        state_next.pu[p] = 1'b1;
        state_next.pd[p] = 1'b0;
      end
      state_next.per[1] = 1'b1;
    end
    // Start-up window keeps pads 3 and 5-8 input-off with pull-ups.
    if (!boot_done)
    begin
      for (int p = 3; p < 9; p++)
      begin
        if (p != 4)
        begin
          state_next.ie[p] = 1'b0;
          state_next.pu[p] = 1'b1;
          state_next.pd[p] = 1'b0;
          state_next.oe[p] = 1'b0;
        end
      end
      state_next.pu[4] = 1'b1;
      state_next.ie[4] = 1'b0;
      state_next.oe[4] = 1'b0;
    end
  end

  // Registers pad controls; reset values are the reset pad states.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg     <= '0;
      state_reg.pu  <= pad_mux_pkg::PAD_PU_RESET;
      state_reg.per <= pad_mux_pkg::PERIPH_IN_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Drives the ports from the registered copy.
  assign pad_out                    = state_reg.out;
  assign pad_oe                     = state_reg.oe;
  assign pad_ie                     = state_reg.ie;
  assign pad_pu                     = state_reg.pu;
  assign pad_pd                     = state_reg.pd;
  assign pad_analog                 = state_reg.an;
  assign gpio_in                    = state_reg.gin & state_reg.ie;
  assign wake_up_in                 = state_reg.per[0];
  assign primary_uart_receive       = state_reg.per[1];
  assign primary_uart_clear_to_send = state_reg.per[2];
  assign secondary_uart_receive     = state_reg.per[3];
  assign spi_data_in                = state_reg.per[4];
  assign mem_i2c_data_in            = state_reg.per[5];

endmodule // pad_function_mux

/* File: dv/pad_function_mux_monitor.sv */
// ****
// Pad mux checker
// ****
module pad_function_mux_monitor
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       fw_wr_en,
  input wire logic [3:0] fw_wr_pad,
  input wire logic [2:0] fw_wr_func,
  input wire logic       host_wr_en,
  input wire logic [3:0] host_wr_pad,
  input wire logic [2:0] host_wr_func,
  input wire logic       boot_done,
  input wire logic       download_mode,
  input wire logic [8:0] pad_oe,
  input wire logic [8:0] pad_ie,
  input wire logic [8:0] pad_pu,
  input wire logic [8:0] pad_analog
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks run on the core clock and rest during reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  AST_RST_PULL: assert property ($fell(sys_rst) |-> pad_pu == 9'h1F8 && (pad_ie | pad_oe) == 9'h000)
    else $error("pad state wrong on reset release");
  AST_BOOT_TIME: assert property ($fell(sys_rst) |-> !boot_done [*8] ##[1:2] boot_done)
    else $error("start-up length wrong");
  AST_STRAP_HOLD: assert property (boot_done && $past(boot_done) |-> $stable(download_mode))
    else $error("boot mode changed after start-up");
  AST_IDLE_BOOT: assert property (!boot_done |-> pad_oe == 9'h000 && pad_ie[8:3] == 6'h00
    && pad_pu[8:3] == 6'h3F)
    else $error("pads active before start-up ends");
  AST_FW_OUT: assert property (boot_done && fw_wr_en && fw_wr_pad < 4'h9 && fw_wr_func == 3'h6
    |-> ##2 pad_oe[$past(fw_wr_pad, 2)])
    else $error("firmware output select not applied");
  AST_HOST_OUT: assert property (boot_done && host_wr_en && !fw_wr_en
    && host_wr_pad < 4'h9 && host_wr_func == 3'h6 |-> ##2 pad_oe[$past(host_wr_pad, 2)])
    else $error("host output select not applied");
  AST_ANALOG_PADS: assert property (pad_analog[0] == 1'b0 && pad_analog[8:3] == 6'h00)
    else $error("analog mode on a digital pad");
  AST_DLOAD_PULL: assert property (boot_done && download_mode |-> pad_pu[4:3] == 2'h3)
    else $error("download mode pull-ups missing");

  cover property ($rose(boot_done) && download_mode);
  cover property ($rose(boot_done) && !download_mode);
  cover property (boot_done && fw_wr_en && host_wr_en);
endmodule // pad_function_mux_monitor

bind pad_function_mux pad_function_mux_monitor i_pad_function_mux_monitor (.*);

/* File: dv/pad_env.sv */
// ****
// Pad wire model
// ****
module pad_env
(
  input  wire logic       ref_clk,
  input  wire logic [8:0] pad_out,
  input  wire logic [8:0] pad_oe,
  input  wire logic [8:0] pad_pu,
  input  wire logic [8:0] pad_pd,
  input  wire logic [8:0] ext_drv,
  input  wire logic [8:0] ext_val,
  output logic      [8:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] float_reg = 9'h0AA;
  // A floating line flips every cycle so no stale level is seen.
  always @(posedge ref_clk) float_reg <= ~float_reg;
  // Device drive wins, then the far-side driver, then the pulls.
  always_comb
  begin
    for (int i = 0; i < 9; i++)
    begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drv[i]) pad_in[i] = ext_val[i];
      else if (pad_pu[i]) pad_in[i] = 1'b1;
      else if (pad_pd[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_reg[i];
    end
  end
endmodule // pad_env

/* File: dv/pad_function_mux_tb.sv */
// ****
// Pad mux testbench
// ****
module pad_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       fw_wr_en = 1'b0, host_wr_en = 1'b0;
  logic [3:0] fw_wr_pad = 4'h0, host_wr_pad = 4'h0;
  logic [2:0] fw_wr_func = 3'h0, host_wr_func = 3'h0;
  logic [1:0] fw_wr_pull = 2'h0, host_wr_pull = 2'h0;
  logic [8:0] gpio_out = 9'h000, ext_drv = 9'h1FF, ext_val = 9'h1DF;
  logic [9:0] src = 10'h000;
  logic [5:0] dst;
  logic       boot_done, download_mode;
  logic [8:0] pad_in, pad_out, pad_oe, pad_ie, pad_pu, pad_pd, pad_analog, gpio_in;
  int         error_cnt = 0, n_compared = 0, cyc = 0;

  pad_function_mux i_pad_function_mux (.pulse_output_0(src[0]), .primary_uart_transmit(src[1]),
    .primary_uart_request_to_send(src[2]), .secondary_uart_transmit(src[3]), .spi_chip_select_out(src[4]),
    .spi_clock_out(src[5]), .spi_data_out(src[6]), .mem_i2c_clock_out(src[7]), .mem_i2c_data_out(src[8]),
    .mem_i2c_data_oe(src[9]), .wake_up_in(dst[0]), .primary_uart_receive(dst[1]),
    .primary_uart_clear_to_send(dst[2]), .secondary_uart_receive(dst[3]), .spi_data_in(dst[4]),
    .mem_i2c_data_in(dst[5]), .*);
  pad_env i_pad_env (.*);

  // Core clock and a ceiling on run length.
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write strobe on firmware, host or both ports, then settle.
  task automatic wr(input logic [1:0] en, input logic [3:0] p, input logic [2:0] f, input logic [2:0] hf,
                    input logic [1:0] u);
    @(negedge ref_clk);
    {fw_wr_pad, fw_wr_func, fw_wr_pull} = {p, f, u};
    {host_wr_pad, host_wr_func, host_wr_pull} = {p, hf, u};
    {host_wr_en, fw_wr_en} = en;
    @(negedge ref_clk);
    {host_wr_en, fw_wr_en} = 2'h0;
    repeat (3) @(negedge ref_clk);
  endtask

  // Reset, try an early write, then wait for start-up to finish.
  task automatic t_boot(input logic strap);
    int n;
    ext_drv[5] = !strap;
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    cmp(pad_pu, 9'h1F8);
    cmp(pad_ie | pad_oe | pad_pd, 9'h000);
    wr(2'h1, 4'h1, 3'h6, 3'h6, 2'h0);
    for (n = 0; n < 40 && boot_done !== 1'b1; n++) @(negedge ref_clk);
    cmp({boot_done, download_mode}, {7'h00, 1'b1, strap});
    cmp(pad_oe, 9'h000);
  endtask

  task automatic out_chk(input logic [3:0] p, input logic [2:0] f, input int b);
    wr(2'h1, p, f, f, 2'h0);
    src = 10'h001 << b;
    repeat (3) @(negedge ref_clk);
    cmp(pad_oe[p] & pad_out[p], 9'h001);
    src = ~(10'h001 << b);
    repeat (3) @(negedge ref_clk);
    cmp(pad_out[p], 9'h000);
    wr(2'h1, p, 3'h7, 3'h7, 2'h0);
  endtask

  task automatic in_chk(input logic [3:0] p, input logic [2:0] f, input int b);
    wr(2'h1, p, f, f, 2'h0);
    cmp(dst[b] & pad_ie[p], 9'h001);
    ext_val[p] = 1'b0;
    repeat (3) @(negedge ref_clk);
    cmp(dst[b], 9'h000);
    ext_val[p] = 1'b1;
    wr(2'h1, p, 3'h7, 3'h7, 2'h0);
  endtask

  task automatic t_outputs();
    out_chk(4'h2, 3'h1, 0);
    out_chk(4'h3, 3'h1, 1);
    out_chk(4'h3, 3'h3, 6);
    out_chk(4'h3, 3'h4, 3);
    out_chk(4'h5, 3'h1, 2);
    out_chk(4'h5, 3'h2, 3);
    out_chk(4'h5, 3'h3, 4);
    out_chk(4'h5, 3'h4, 1);
    out_chk(4'h6, 3'h3, 5);
    out_chk(4'h7, 3'h2, 7);
    out_chk(4'h7, 3'h3, 6);
    // Pad 8 memory data line follows the peripheral's own output enable.
    wr(2'h1, 4'h8, 3'h2, 3'h2, 2'h0);
    src = 10'h300;
    repeat (3) @(negedge ref_clk);
    cmp({pad_oe[8], pad_out[8]}, 9'h003);
    src = 10'h100;
    repeat (3) @(negedge ref_clk);
    cmp(pad_oe[8], 9'h000);
    wr(2'h1, 4'h8, 3'h7, 3'h7, 2'h0);
  endtask

  task automatic t_inputs();
    src = 10'h000;
    in_chk(4'h0, 3'h1, 0);
    in_chk(4'h4, 3'h1, 1);
    in_chk(4'h4, 3'h3, 4);
    in_chk(4'h4, 3'h4, 3);
    in_chk(4'h6, 3'h1, 2);
    in_chk(4'h6, 3'h2, 3);
    in_chk(4'h6, 3'h4, 1);
    in_chk(4'h8, 3'h2, 5);
    in_chk(4'h8, 3'h3, 4);
    cmp(dst[3:1], 9'h007);
  endtask

  task automatic t_gpio();
    gpio_out = 9'h002;
    wr(2'h1, 4'h1, pad_mux_pkg::FUNC_GPIO_OUT, 3'h0, 2'h0);
    cmp(pad_out & pad_oe, 9'h002);
    wr(2'h1, 4'h1, pad_mux_pkg::FUNC_GPIO_IN, 3'h0, 2'h0);
    cmp(gpio_in[1], 9'h001);
    wr(2'h1, 4'h1, pad_mux_pkg::FUNC_ANALOG, 3'h0, 2'h0);
    cmp(pad_analog, 9'h002);
    cmp(pad_ie[1], 9'h000);
    wr(2'h1, 4'h0, 3'h0, 3'h0, pad_mux_pkg::PULL_DOWN);
    cmp({pad_pu[0], pad_pd[0]}, 9'h001);
    wr(2'h2, 4'h0, 3'h0, 3'h6, pad_mux_pkg::PULL_UP);
    cmp({pad_pu[0], pad_pd[0]}, 9'h002);
    wr(2'h2, 4'h5, 3'h7, 3'h7, 2'h0);
    cmp(pad_pu[5], 9'h000);
    wr(2'h3, 4'h2, pad_mux_pkg::FUNC_GPIO_OUT, pad_mux_pkg::FUNC_ANALOG, 2'h0);
    cmp({pad_oe[2], pad_analog[2]}, 9'h002);
    wr(2'h2, 4'h2, 3'h0, pad_mux_pkg::FUNC_ANALOG, 2'h0);
    cmp(pad_analog[2:1], 9'h003);
  endtask

  task automatic t_spi();
    wr(2'h1, 4'h3, 3'h3, 3'h3, 2'h0);
    wr(2'h1, 4'h7, 3'h3, 3'h3, 2'h0);
    cmp({pad_oe[3], pad_oe[7]}, 9'h002);
    wr(2'h1, 4'h4, 3'h3, 3'h3, 2'h0);
    wr(2'h1, 4'h8, 3'h3, 3'h3, 2'h0);
    ext_val[4] = 1'b0;
    repeat (3) @(negedge ref_clk);
    cmp(dst[4], 9'h000);
    ext_val[4] = 1'b1;
  endtask

  task automatic t_dload();
    t_boot(1'b1);
    cmp(pad_pu[4:3], 9'h003);
    wr(2'h1, 4'h3, 3'h1, 3'h1, 2'h2);
    wr(2'h1, 4'h4, 3'h1, 3'h1, 2'h2);
    ext_val[4] = 1'b0;
    repeat (3) @(negedge ref_clk);
    cmp({pad_oe[3], pad_pu[4:3], dst[1]}, 9'h007);
  endtask

  // Main sequence.
  initial
  begin
    t_boot(1'b0);
    t_outputs();
    t_inputs();
    t_gpio();
    t_spi();
    t_dload();
    stop_test();
  end
endmodule // pad_function_mux_tb
